/* File: pdcrd_pkg.sv */
/*
 pdcrd_pkg: request encodings, feature selectors, descriptor layout and
 decoded request kinds for the power-delivery class request decoder.
 assumes the usb core hands over setup fields already split out.
*/
package pdcrd_pkg;
   localparam int          NUM_PORTS    = 16;
   localparam int          MAX_OBJS     = 7;
   // request types
   localparam logic [7:0]  TYPE_PORT_OUT = 8'h23;
   localparam logic [7:0]  TYPE_PORT_IN  = 8'hA3;
   localparam logic [7:0]  TYPE_DEV_IN   = 8'h80;
   localparam logic [7:0]  TYPE_DEV_OUT  = 8'h00;
   // request codes
   localparam logic [7:0]  REQ_GET_STATUS  = 8'h00;
   localparam logic [7:0]  REQ_CLEAR_FEAT  = 8'h01;
   localparam logic [7:0]  REQ_SET_FEAT    = 8'h03;
   localparam logic [7:0]  REQ_PARTNER_OBJ = 8'h14;
   localparam logic [7:0]  REQ_BATTERY     = 8'h15;
   localparam logic [7:0]  REQ_SET_OBJ     = 8'h16;
   localparam logic [7:0]  REQ_VMSG_FETCH  = 8'h17;
   localparam logic [7:0]  REQ_VMSG_SEND   = 8'h18;
   // feature selectors
   localparam logic [15:0] SEL_BATT_WAKE   = 16'h0028;
   localparam logic [15:0] SEL_HOST_AWARE  = 16'h0029;
   localparam logic [15:0] SEL_POLICY_MODE = 16'h002A;
   localparam logic [15:0] SEL_ROLE_SWAP   = 16'h002B;
   localparam logic [15:0] SEL_CHANGE_ACK  = 16'h0031;
   localparam logic [15:0] SEL_CABLE_RESET = 16'h0032;
   localparam logic [15:0] SEL_CHARGE_POL  = 16'h0036;
   // wValue and wLength figures
   localparam logic [15:0] VAL_ZERO    = 16'h0000;
   localparam logic [15:0] VAL_ONE     = 16'h0001;
   localparam logic [15:0] VAL_SOP_MAX = 16'h0002;
   localparam logic [15:0] LEN_ZERO    = 16'h0000;
   localparam logic [15:0] LEN_TWO     = 16'h0002;
   localparam logic [15:0] LEN_EIGHT   = 16'h0008;
   // source-port capability descriptor layout
   localparam logic [7:0]  DEVCAP_TYPE   = 8'h10;
   localparam logic [7:0]  SRC_CAP_TYPE  = 8'h01;
   localparam logic [5:0]  OFF_LEN       = 6'h00;
   localparam logic [5:0]  OFF_DTYPE     = 6'h01;
   localparam logic [5:0]  OFF_CTYPE     = 6'h02;
   localparam logic [5:0]  OFF_RSVD0     = 6'h03;
   localparam logic [5:0]  OFF_CAPS_LO   = 6'h04;
   localparam logic [5:0]  OFF_CAPS_HI   = 6'h05;
   localparam logic [5:0]  OFF_OBJ_COUNT = 6'h06;
   localparam logic [5:0]  OFF_RSVD1     = 6'h07;
   localparam logic [5:0]  OFF_OBJS      = 6'h08;

   typedef enum logic [3:0] {
      KIND_NONE, KIND_PORT_CLEAR, KIND_BATTERY, KIND_PARTNER_OBJS,
      KIND_PORT_STATUS, KIND_DEV_SET, KIND_PORT_SET, KIND_PORT_OBJS,
      KIND_VMSG_FETCH, KIND_VMSG_SEND
   } pdcrd_kind_e;

   typedef enum logic {CLR_IDLE, CLR_WAIT_MASK} pdcrd_clr_e;
endpackage : pdcrd_pkg

/* File: pdcrd_desc_rom.sv */
/*
 pdcrd_desc_rom: per-port source capability store and byte server for
 the source-port capability descriptor.
 assumes firmware fills entries through the cfg port before enumeration.
*/
`timescale 1ns/1ns
module pdcrd_desc_rom (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        cfg_we,
   input  wire logic [3:0]  cfg_port,
   input  wire logic        cfg_hdr,
   input  wire logic [2:0]  cfg_obj_idx,
   input  wire logic [2:0]  cfg_caps,
   input  wire logic [2:0]  cfg_count,
   input  wire logic [31:0] cfg_obj,
   input  wire logic        rd_valid,
   input  wire logic [3:0]  rd_port,
   input  wire logic [5:0]  rd_offset,
   output logic [7:0]       rd_byte_ff,
   output logic             rd_valid_ff
);
   // sixteen entries cover the largest hub
   logic [2:0]  caps_ff [pdcrd_pkg::NUM_PORTS];
   logic [2:0]  cnt_ff  [pdcrd_pkg::NUM_PORTS];
   logic [31:0] obj_ff  [pdcrd_pkg::NUM_PORTS][pdcrd_pkg::MAX_OBJS];
   logic [5:0]  len_c;
   logic [5:0]  rel_c;
   logic [2:0]  cnt_c;
   logic [31:0] word_c;
   logic [7:0]  nxt_byte;

   always_ff @(posedge mclk)
   begin
      for (int p = 0; p < pdcrd_pkg::NUM_PORTS; p++)
      begin
         if (srst)
         begin
            caps_ff[p] <= 3'h0;
            cnt_ff[p]  <= 3'h0;
         end
         else if (cfg_we && cfg_hdr && cfg_port == 4'(p))
         begin
            caps_ff[p] <= cfg_caps;
            cnt_ff[p]  <= cfg_count;
         end
      end
   end

   // objects are data, so no reset is spent on them
   always_ff @(posedge mclk)
   begin
      if (cfg_we && !cfg_hdr && cfg_obj_idx < 3'(pdcrd_pkg::MAX_OBJS))
         obj_ff[cfg_port][cfg_obj_idx] <= cfg_obj;
   end

   always_comb
   begin
      cnt_c  = cnt_ff[rd_port];
      len_c  = pdcrd_pkg::OFF_OBJS + {1'b0, cnt_c, 2'b00};
      rel_c  = rd_offset - pdcrd_pkg::OFF_OBJS;
      word_c = (rel_c[4:2] < 3'(pdcrd_pkg::MAX_OBJS)) ? obj_ff[rd_port][rel_c[4:2]] : 32'h0000_0000;
      if (rd_offset == pdcrd_pkg::OFF_LEN)
         nxt_byte = {2'b00, len_c};
      else if (rd_offset == pdcrd_pkg::OFF_DTYPE)
         nxt_byte = pdcrd_pkg::DEVCAP_TYPE;
      else if (rd_offset == pdcrd_pkg::OFF_CTYPE)
         nxt_byte = pdcrd_pkg::SRC_CAP_TYPE;
      else if (rd_offset == pdcrd_pkg::OFF_CAPS_LO)
         nxt_byte = {5'h00, caps_ff[rd_port]};
      else if (rd_offset == pdcrd_pkg::OFF_OBJ_COUNT)
         nxt_byte = {5'h00, cnt_c};
      else if (rd_offset >= pdcrd_pkg::OFF_OBJS && rd_offset < len_c)
         nxt_byte = word_c[{rel_c[1:0], 3'b000} +: 8];
      else
         nxt_byte = 8'h00;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rd_byte_ff  <= 8'h00;
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         rd_byte_ff  <= rd_valid ? nxt_byte : 8'h00;
         rd_valid_ff <= rd_valid;
      end
   end

   hdr_zero_a: assert property (@(posedge mclk) disable iff (srst)
      rd_valid && rd_offset == pdcrd_pkg::OFF_RSVD0 |=> rd_byte_ff == 8'h00)
      else $error("reserved header byte not zero");
   caps_hi_a: assert property (@(posedge mclk) disable iff (srst)
      rd_valid && rd_offset == pdcrd_pkg::OFF_CAPS_HI |=> rd_byte_ff == 8'h00)
      else $error("capability upper byte not zero");
   len_fit_a: assert property (@(posedge mclk) disable iff (srst)
      rd_valid && rd_offset == pdcrd_pkg::OFF_LEN
      |=> rd_byte_ff[1:0] == 2'b00 && rd_byte_ff >= 8'h08)
      else $error("descriptor length not header plus objects");
endmodule : pdcrd_desc_rom

/* File: pdcrd_decoder.sv */
/*
 pdcrd_decoder: decodes power-delivery class control requests, keeps
 per-port change status, gates hub notifications and serves the
 source-port capability descriptor.
 assumes setup fields, mask data and port events arrive on mclk from
 the usb core; strap inputs are static after reset.
*/
`timescale 1ns/1ns
module pdcrd_decoder (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        is_hub,
   input  wire logic        has_battery,
   input  wire logic [4:0]  hub_port_count,
   input  wire logic        setup_valid,
   input  wire logic [7:0]  setup_type,
   input  wire logic [7:0]  setup_req,
   input  wire logic [15:0] setup_value,
   input  wire logic [15:0] setup_index,
   input  wire logic [15:0] setup_length,
   input  wire logic        ack_mask_valid,
   input  wire logic [15:0] ack_mask,
   input  wire logic        port_event_valid,
   input  wire logic [3:0]  port_event_idx,
   input  wire logic [15:0] port_event_mask,
   input  wire logic        port_event_host_caused,
   input  wire logic        intr_ready,
   input  wire logic [15:0] source_port_bitmap,
   input  wire logic        cfg_we,
   input  wire logic [3:0]  cfg_port,
   input  wire logic        cfg_hdr,
   input  wire logic [2:0]  cfg_obj_idx,
   input  wire logic [2:0]  cfg_caps,
   input  wire logic [2:0]  cfg_count,
   input  wire logic [31:0] cfg_obj,
   input  wire logic        desc_rd_valid,
   input  wire logic [3:0]  desc_ordinal,
   input  wire logic [5:0]  desc_offset,
   output logic             req_ok_ff,
   output logic             req_stall_ff,
   output pdcrd_pkg::pdcrd_kind_e req_kind_ff,
   output logic [15:0]      req_value_ff,
   output logic [15:0]      req_index_ff,
   output logic             host_aware_ff,
   output logic [15:0]      change_summary_ff,
   output logic [15:0]      port_change_word_ff,
   output logic             intr_valid,
   output logic [16:0]      intr_bitmap,
   output logic [7:0]       desc_byte_ff,
   output logic             desc_valid_ff,
   output logic             desc_none_ff
);
   pdcrd_pkg::pdcrd_kind_e kind_c;
   pdcrd_pkg::pdcrd_clr_e  clr_state_ff;
   logic        port_ok_c;
   logic        port_req_c;
   logic        gate_c;
   logic        good_c;
   logic        aware_req_c;
   logic        event_ok_c;
   logic        clr_go_c;
   logic [3:0]  clr_port_ff;
   logic [15:0] chg_ff  [pdcrd_pkg::NUM_PORTS];
   logic [15:0] nxt_chg [pdcrd_pkg::NUM_PORTS];
   logic [15:0] notify_ff;
   logic [15:0] nxt_notify;
   logic [15:0] eff_bitmap_c;
   logic [4:0]  desc_hit_c;

   function automatic logic is_port_sel(input logic [15:0] v);
      return v >= pdcrd_pkg::SEL_ROLE_SWAP && v <= pdcrd_pkg::SEL_CABLE_RESET;
   endfunction : is_port_sel
   function automatic logic is_dev_sel(input logic [15:0] v);
      return v == pdcrd_pkg::SEL_BATT_WAKE || v == pdcrd_pkg::SEL_HOST_AWARE ||
             v == pdcrd_pkg::SEL_POLICY_MODE || v == pdcrd_pkg::SEL_CHARGE_POL;
   endfunction : is_dev_sel
   function automatic pdcrd_pkg::pdcrd_kind_e decode_kind(
      input logic [7:0]  t,
      input logic [7:0]  r,
      input logic [15:0] v,
      input logic [15:0] l);
      pdcrd_pkg::pdcrd_kind_e k;
      k = pdcrd_pkg::KIND_NONE;
      if (t == pdcrd_pkg::TYPE_PORT_OUT)
      begin
         if (r == pdcrd_pkg::REQ_CLEAR_FEAT && is_port_sel(v) && l == pdcrd_pkg::LEN_TWO)
            k = pdcrd_pkg::KIND_PORT_CLEAR;
         else if (r == pdcrd_pkg::REQ_SET_FEAT && is_port_sel(v) && l == pdcrd_pkg::LEN_ZERO)
            k = pdcrd_pkg::KIND_PORT_SET;
         else if (r == pdcrd_pkg::REQ_SET_OBJ && v == pdcrd_pkg::VAL_ZERO)
            k = pdcrd_pkg::KIND_PORT_OBJS;
         else if (r == pdcrd_pkg::REQ_VMSG_SEND && v <= pdcrd_pkg::VAL_SOP_MAX)
            k = pdcrd_pkg::KIND_VMSG_SEND;
      end
      else if (t == pdcrd_pkg::TYPE_PORT_IN)
      begin
         if (r == pdcrd_pkg::REQ_PARTNER_OBJ && v <= pdcrd_pkg::VAL_ONE)
            k = pdcrd_pkg::KIND_PARTNER_OBJS;
         else if (r == pdcrd_pkg::REQ_GET_STATUS && v == pdcrd_pkg::VAL_ONE &&
                  l == pdcrd_pkg::LEN_EIGHT)
            k = pdcrd_pkg::KIND_PORT_STATUS;
         else if (r == pdcrd_pkg::REQ_VMSG_FETCH && v == pdcrd_pkg::VAL_ZERO)
            k = pdcrd_pkg::KIND_VMSG_FETCH;
      end
      else if (t == pdcrd_pkg::TYPE_DEV_IN)
      begin
         if (r == pdcrd_pkg::REQ_BATTERY && v == pdcrd_pkg::VAL_ZERO &&
             l == pdcrd_pkg::LEN_EIGHT)
            k = pdcrd_pkg::KIND_BATTERY;
      end
      else if (t == pdcrd_pkg::TYPE_DEV_OUT)
      begin
         if (r == pdcrd_pkg::REQ_SET_FEAT && is_dev_sel(v) && l == pdcrd_pkg::LEN_ZERO)
            k = pdcrd_pkg::KIND_DEV_SET;
      end
      return k;
   endfunction : decode_kind
   // nth set bit, lowest port first; bit 4 flags a hit
   function automatic logic [4:0] nth_port(
      input logic [15:0] bm,
      input logic [3:0]  n);
      logic [4:0] seen;
      logic [4:0] res;
      seen = 5'h00;
      res  = 5'h00;
      for (int i = 0; i < pdcrd_pkg::NUM_PORTS; i++)
      begin
         if (bm[i] && !res[4] && seen == {1'b0, n})
            res = {1'b1, 4'(i)};
         if (bm[i])
            seen = seen + 5'h01;
      end
      return res;
   endfunction : nth_port
   always_comb
   begin
      kind_c      = decode_kind(setup_type, setup_req, setup_value, setup_length);
      port_ok_c   = setup_index[7:0] != 8'h00 && setup_index[7:0] <= {3'b000, hub_port_count};
      port_req_c  = kind_c != pdcrd_pkg::KIND_NONE && kind_c != pdcrd_pkg::KIND_BATTERY &&
                    kind_c != pdcrd_pkg::KIND_DEV_SET;
      aware_req_c = kind_c == pdcrd_pkg::KIND_DEV_SET && setup_value == pdcrd_pkg::SEL_HOST_AWARE;
      // a hub is silent until host aware, battery and the aware notice pass
      gate_c      = is_hub && !host_aware_ff && kind_c != pdcrd_pkg::KIND_BATTERY && !aware_req_c;
      good_c      = kind_c != pdcrd_pkg::KIND_NONE && !(port_req_c && !(is_hub && port_ok_c)) &&
                    !gate_c && !(kind_c == pdcrd_pkg::KIND_BATTERY && !has_battery);
   end
   // one answer per setup, every class request decoded
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         req_ok_ff    <= 1'b0;
         req_stall_ff <= 1'b0;
         req_kind_ff  <= pdcrd_pkg::KIND_NONE;
         req_value_ff <= 16'h0000;
         req_index_ff <= 16'h0000;
      end
      else
      begin
         req_ok_ff    <= setup_valid && good_c;
         req_stall_ff <= setup_valid && !good_c;
         if (setup_valid)
         begin
            req_kind_ff  <= good_c ? kind_c : pdcrd_pkg::KIND_NONE;
            req_value_ff <= setup_value;
            req_index_ff <= setup_index;
         end
      end
   end
   // host-aware notice; only a bus or device reset drops it
   always_ff @(posedge mclk)
   begin
      if (srst)
         host_aware_ff <= 1'b0;
      else if (setup_valid && good_c && aware_req_c)
         host_aware_ff <= 1'b1;
   end

   // change acknowledge waits for its two-byte mask data stage
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         clr_state_ff <= pdcrd_pkg::CLR_IDLE;
         clr_port_ff  <= 4'h0;
      end
      else
      begin
         case (clr_state_ff)
            pdcrd_pkg::CLR_IDLE:
            begin
               if (setup_valid && good_c && kind_c == pdcrd_pkg::KIND_PORT_CLEAR &&
                   setup_value == pdcrd_pkg::SEL_CHANGE_ACK)
               begin
                  clr_state_ff <= pdcrd_pkg::CLR_WAIT_MASK;
                  clr_port_ff  <= 4'(setup_index[7:0] - 8'h01);
               end
            end
            pdcrd_pkg::CLR_WAIT_MASK:
            begin
               // a fresh setup abandons a data stage that never came
               if (ack_mask_valid || setup_valid)
                  clr_state_ff <= pdcrd_pkg::CLR_IDLE;
            end
         endcase
      end
   end

   always_comb
   begin
      clr_go_c   = clr_state_ff == pdcrd_pkg::CLR_WAIT_MASK && ack_mask_valid && !setup_valid;
      event_ok_c = port_event_valid && !port_event_host_caused && is_hub &&
                   {1'b0, port_event_idx} < hub_port_count && port_event_mask != 16'h0000;
      for (int p = 0; p < pdcrd_pkg::NUM_PORTS; p++)
      begin
         nxt_chg[p] = chg_ff[p];
         if (clr_go_c && clr_port_ff == 4'(p))
            nxt_chg[p] = nxt_chg[p] & ~ack_mask;
         // set wins over a clear in the same cycle
         if (event_ok_c && port_event_idx == 4'(p))
            nxt_chg[p] = nxt_chg[p] | port_event_mask;
      end
      // sole delivery path, held until host aware
      nxt_notify = (intr_valid && intr_ready) ? 16'h0000 : notify_ff;
      if (event_ok_c)
         nxt_notify[port_event_idx] = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      for (int p = 0; p < pdcrd_pkg::NUM_PORTS; p++)
      begin
         if (srst)
         begin
            chg_ff[p]            <= 16'h0000;
            change_summary_ff[p] <= 1'b0;
         end
         else
         begin
            chg_ff[p]            <= nxt_chg[p];
            // summary drops only once every change is acknowledged
            change_summary_ff[p] <= |nxt_chg[p];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         port_change_word_ff <= 16'h0000;
      else if (setup_valid && good_c && kind_c == pdcrd_pkg::KIND_PORT_STATUS)
         port_change_word_ff <= chg_ff[4'(setup_index[7:0] - 8'h01)];
   end
   always_ff @(posedge mclk)
   begin
      if (srst)
         notify_ff <= 16'h0000;
      else
         notify_ff <= nxt_notify;
   end
   // no notification before the host is aware
   assign intr_valid  = host_aware_ff && notify_ff != 16'h0000;
   assign intr_bitmap = {notify_ff, 1'b0};
   // a peripheral owns at most its first port
   assign eff_bitmap_c = is_hub ? source_port_bitmap : (source_port_bitmap & 16'h0001);
   // ordinal maps to ascending source ports
   assign desc_hit_c   = nth_port(eff_bitmap_c, desc_ordinal);

   always_ff @(posedge mclk)
   begin
      if (srst)
         desc_none_ff <= 1'b0;
      else
         desc_none_ff <= desc_rd_valid && !desc_hit_c[4];
   end

   pdcrd_desc_rom u_rom (
      .mclk        (mclk),
      .srst        (srst),
      .cfg_we      (cfg_we),
      .cfg_port    (cfg_port),
      .cfg_hdr     (cfg_hdr),
      .cfg_obj_idx (cfg_obj_idx),
      .cfg_caps    (cfg_caps),
      .cfg_count   (cfg_count),
      .cfg_obj     (cfg_obj),
      .rd_valid    (desc_rd_valid && desc_hit_c[4]),
      .rd_port     (desc_hit_c[3:0]),
      .rd_offset   (desc_offset),
      .rd_byte_ff  (desc_byte_ff),
      .rd_valid_ff (desc_valid_ff)
   );
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   sequence s_aware_notice;
      setup_valid && setup_type == pdcrd_pkg::TYPE_DEV_OUT &&
      setup_req == pdcrd_pkg::REQ_SET_FEAT && setup_value == pdcrd_pkg::SEL_HOST_AWARE &&
      setup_length == pdcrd_pkg::LEN_ZERO;
   endsequence
   one_answer_a: assert property (
      setup_valid |=> req_ok_ff != req_stall_ff)
      else $error("setup not answered exactly once");
   no_spur_a: assert property (
      !setup_valid |=> !req_ok_ff && !req_stall_ff)
      else $error("answer without setup");
   aware_gate_a: assert property (
      setup_valid && is_hub && !host_aware_ff && setup_type == pdcrd_pkg::TYPE_PORT_IN
      |=> req_stall_ff)
      else $error("port request answered before host aware");
   aware_set_a: assert property (
      s_aware_notice |=> req_ok_ff && host_aware_ff)
      else $error("host-aware notice not taken");
   periph_only_a: assert property (
      setup_valid && !is_hub && setup_type == pdcrd_pkg::TYPE_PORT_OUT |=> req_stall_ff)
      else $error("hub-only request taken by peripheral");
   batt_len_a: assert property (
      setup_valid && setup_type == pdcrd_pkg::TYPE_DEV_IN &&
      setup_length != pdcrd_pkg::LEN_EIGHT |=> req_stall_ff)
      else $error("battery query with wrong length taken");
   port_zero_a: assert property (
      setup_valid && setup_type == pdcrd_pkg::TYPE_PORT_IN && setup_index[7:0] == 8'h00
      |=> req_stall_ff)
      else $error("port zero accepted");
   intr_gate_a: assert property (
      intr_valid |-> host_aware_ff && intr_bitmap[0] == 1'b0)
      else $error("notification without host aware");
   host_caused_a: assert property (
      port_event_valid && port_event_host_caused && !intr_ready |=> notify_ff == $past(notify_ff))
      else $error("notify changed by host-caused event");
   summary_hold_a: assert property (
      !ack_mask_valid || setup_valid |=> (change_summary_ff & $past(change_summary_ff)) ==
                                         $past(change_summary_ff))
      else $error("summary dropped without acknowledge");
endmodule : pdcrd_decoder

/* File: pdcrd_host_model.sv */
/* pdcrd_host_model: host side of the control pipe, issuing class setups
 and clear-change masks. assumes callers enter its tasks at a falling edge. */
`timescale 1ns/1ns
module pdcrd_host_model (
   input  wire logic  mclk,
   output logic       setup_valid,
   output logic [7:0] setup_type,
   output logic [7:0] setup_req,
   output logic [15:0] setup_value,
   output logic [15:0] setup_index,
   output logic [15:0] setup_length,
   output logic       ack_mask_valid,
   output logic [15:0] ack_mask
);
   initial {setup_valid, ack_mask_valid, setup_type, setup_req} = 18'h0;
   initial {setup_value, setup_index, setup_length, ack_mask} = 64'h0;
   task automatic issue(input logic [7:0] t, r, input logic [15:0] v, i, l);
      {setup_type, setup_req, setup_value, setup_index, setup_length} = {t, r, v, i, l};
      setup_valid = 1'b1;
      @(negedge mclk);
      setup_valid = 1'b0;
      // stale fields must not look valid
      {setup_type, setup_req, setup_value, setup_index, setup_length} = ~{t, r, v, i, l};
   endtask : issue
   task automatic ack(input logic [15:0] m);
      ack_mask = m;
      ack_mask_valid = 1'b1;
      @(negedge mclk);
      ack_mask_valid = 1'b0;
      ack_mask = ~m;
   endtask : ack
endmodule : pdcrd_host_model

/* File: tb_top.sv */
/* tb_top: decoder with host model and scenario tasks.
 assumes a hub with four ports, sources on ports 1 and 3. */
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
   logic mclk = 1'b0, srst = 1'b1, is_hub = 1'b1, has_battery = 1'b1, intr_ready = 1'b0;
   logic [4:0] hub_port_count = 5'h4;
   logic [15:0] source_port_bitmap = 16'h5, port_event_mask = 16'h0, ack_mask;
   logic port_event_valid = 1'b0, port_event_host_caused = 1'b0, cfg_we = 1'b0;
   logic [3:0] port_event_idx = 4'h0, cfg_port = 4'h0, desc_ordinal = 4'h0;
   logic cfg_hdr = 1'b0, desc_rd_valid = 1'b0, setup_valid, ack_mask_valid;
   logic [2:0] cfg_obj_idx = 3'h0, cfg_caps = 3'h3, cfg_count = 3'h1;
   logic [31:0] cfg_obj = 32'h1234_5678;
   logic [5:0] desc_offset = 6'h0;
   logic [7:0] setup_type, setup_req, desc_byte_ff;
   logic [15:0] setup_value, setup_index, setup_length, change_summary_ff;
   logic [15:0] req_value_ff, req_index_ff, port_change_word_ff;
   logic req_ok_ff, req_stall_ff, host_aware_ff, intr_valid, desc_valid_ff, desc_none_ff;
   logic [16:0] intr_bitmap;
   pdcrd_pkg::pdcrd_kind_e req_kind_ff;
   int failures = 0, tests_run = 0;
   always #10 mclk = ~mclk;
   pdcrd_host_model pdcrd_host_model_inst (.mclk, .setup_valid, .setup_type, .setup_req,
      .setup_value, .setup_index, .setup_length, .ack_mask_valid, .ack_mask);
   pdcrd_decoder pdcrd_decoder_inst (.mclk, .srst, .is_hub, .has_battery, .hub_port_count,
      .setup_valid, .setup_type, .setup_req, .setup_value, .setup_index, .setup_length,
      .ack_mask_valid, .ack_mask, .port_event_valid, .port_event_idx, .port_event_mask,
      .port_event_host_caused, .intr_ready, .source_port_bitmap, .cfg_we, .cfg_port, .cfg_hdr,
      .cfg_obj_idx, .cfg_caps, .cfg_count, .cfg_obj, .desc_rd_valid, .desc_ordinal,
      .desc_offset, .req_ok_ff, .req_stall_ff, .req_kind_ff, .req_value_ff, .req_index_ff,
      .host_aware_ff, .change_summary_ff, .port_change_word_ff, .intr_valid, .intr_bitmap,
      .desc_byte_ff, .desc_valid_ff, .desc_none_ff);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic req(input logic [7:0] t, r, input logic [15:0] v, i, l, input logic ok);
      pdcrd_host_model_inst.issue(t, r, v, i, l);
      `CHK(req_ok_ff, ok)
      `CHK(req_stall_ff, ~ok)
      `CHK(req_value_ff, v)
      `CHK(req_index_ff, i)
      @(negedge mclk);
   endtask : req
   task automatic ev(input logic [3:0] p, input logic [15:0] m, input logic hc);
      {port_event_idx, port_event_mask, port_event_host_caused} = {p, m, hc};
      port_event_valid = 1'b1;
      @(negedge mclk);
      port_event_valid = 1'b0;
      @(negedge mclk);
   endtask : ev
   task automatic rd(input logic [3:0] o, input logic [5:0] f);
      @(negedge mclk);
      {desc_ordinal, desc_offset, desc_rd_valid} = {o, f, 1'b1};
      @(negedge mclk);
      desc_rd_valid = 1'b0;
   endtask : rd
   task automatic gate_scn;
      int n;
      `CHK(req_kind_ff, pdcrd_pkg::KIND_NONE)
      ev(4'h0, 16'h2, 1'b0);
      `CHK(intr_valid, 1'b0)
      req(8'hA3, 8'h0, 16'h1, 16'h1, 16'h8, 1'b0);
      req(8'h80, 8'h15, 16'h0, 16'h1, 16'h8, 1'b1);
      req(8'h0, 8'h3, 16'h29, 16'h0, 16'h0, 1'b1);
      for (n = 0; n < 4 && intr_valid !== 1'b1; n++)
         @(negedge mclk);
      failures += (n == 4);
      if (n == 4)
         end_sim();
      `CHK(intr_bitmap, 17'h2)
      intr_ready = 1'b1;
      @(negedge mclk);
      intr_ready = 1'b0;
      `CHK(intr_valid, 1'b0)
   endtask : gate_scn
   task automatic code_scn;
      logic [15:0] dsel [4] = '{16'h28, 16'h29, 16'h2A, 16'h36};
      for (logic [15:0] s = 16'h2B; s <= 16'h32; s++)
         req(8'h23, 8'h3, s, 16'h2, 16'h0, 1'b1);
      foreach (dsel[k])
         req(8'h0, 8'h3, dsel[k], 16'h0, 16'h0, 1'b1);
      req(8'h0, 8'h3, 16'h37, 16'h0, 16'h0, 1'b0);
      req(8'hA3, 8'h14, 16'h1, 16'h4, 16'h1C, 1'b1);
      req(8'h23, 8'h16, 16'h0, 16'h3, 16'h8, 1'b1);
      req(8'hA3, 8'h17, 16'h0, 16'h3, 16'h14, 1'b1);
      req(8'h23, 8'h18, 16'h2, 16'h3, 16'hC, 1'b1);
      req(8'h23, 8'h19, 16'h0, 16'h3, 16'h0, 1'b0);
      req(8'hA3, 8'h0, 16'h1, 16'h3, 16'h2, 1'b0);
      req(8'h23, 8'h1, 16'h31, 16'h5, 16'h2, 1'b0);
   endtask : code_scn
   task automatic clear_scn;
      ev(4'h1, 16'h6, 1'b0);
      ev(4'h2, 16'h8, 1'b1);
      `CHK(change_summary_ff[2:1], 2'b01)
      `CHK(intr_bitmap[3:2], 2'b01)
      req(8'h23, 8'h1, 16'h31, 16'h2, 16'h2, 1'b1);
      pdcrd_host_model_inst.ack(16'h2);
      `CHK(change_summary_ff[1], 1'b1)
      req(8'hA3, 8'h0, 16'h1, 16'h2, 16'h8, 1'b1);
      `CHK(req_kind_ff, pdcrd_pkg::KIND_PORT_STATUS)
      `CHK(port_change_word_ff, 16'h4)
      req(8'h23, 8'h1, 16'h31, 16'h2, 16'h2, 1'b1);
      pdcrd_host_model_inst.ack(16'h4);
      `CHK(change_summary_ff[1], 1'b0)
   endtask : clear_scn
   task automatic desc_scn;
      logic [7:0] exp [12] = '{8'hC, 8'h10, pdcrd_pkg::SRC_CAP_TYPE, 8'h0, 8'h3, 8'h0,
                              8'h1, 8'h0, 8'h78, 8'h56, 8'h34, 8'h12};
      {cfg_hdr, cfg_we} = 2'b11;
      @(negedge mclk);
      cfg_hdr = 1'b0;
      @(negedge mclk);
      cfg_we = 1'b0;
      // full header and one object of the first source port
      for (int k = 0; k < 12; k++)
      begin
         rd(4'h0, 6'(k));
         `CHK({desc_valid_ff, desc_byte_ff}, {1'b1, exp[k]})
      end
      rd(4'h1, 6'h0);
      `CHK(desc_byte_ff, 8'h8)
      rd(4'h2, 6'h0);
      `CHK(desc_none_ff, 1'b1)
   endtask : desc_scn
   task automatic periph_scn;
      // peripheral strap taken under a mid-run reset
      {srst, is_hub} = 2'b10;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      `CHK(host_aware_ff, 1'b0)
      req(8'h23, 8'h3, 16'h2B, 16'h1, 16'h0, 1'b0);
      req(8'h80, 8'h15, 16'h0, 16'h1, 16'h8, 1'b1);
      req(8'h0, 8'h3, 16'h28, 16'h0, 16'h0, 1'b1);
      rd(4'h0, 6'h0);
      `CHK({desc_valid_ff, desc_byte_ff}, 9'h108)
      rd(4'h1, 6'h0);
      `CHK(desc_none_ff, 1'b1)
   endtask : periph_scn
   initial
   begin
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      gate_scn();
      code_scn();
      clear_scn();
      desc_scn();
      periph_scn();
      end_sim();
   end
endmodule : tb_top
